//--- include/cis_pkg.sv
/*
 * Package for the instruction-slice execution block: operation codes,
 * widths, flag positions, cycle counts and reset values.
 * Assumes the core's decoder hands one operation at a time with operands
 * already read from the working register file.
 */
// Function
// (RULE1) signed by signed multiply into a register pair, one cycle, no flags; code holds busy two cycles and writes the pair at issue+2 and issue+3
// (RULE2) signed by unsigned multiply into register pair, one cycle, no flags; code holds busy two cycles and writes the pair at issue+2 and issue+3
// (RULE3) unsigned times signed multiply into register pair, one cycle; code holds busy two cycles and writes the pair at issue+2 and issue+3
// (RULE4) signed register by zero-extended 5-bit literal into pair, no flags
// (RULE5) unsigned register times unsigned 5-bit literal into pair, one cycle; code holds busy two cycles and writes the pair at issue+2 and issue+3
// (RULE6) negate is inverse plus one; updates C, DC, N, OV and Z flags
// (RULE7) single pop moves stack top into one register in one cycle, no flags
// (RULE8) double pop fills consecutive register pair in two cycles, no flags
// (RULE9) single push places a value on stack top in one cycle, no flags
// (RULE10) double push stores a register pair in two cycles, no flags
// (RULE11) power save bit picks sleep or idle, updates watchdog, sleep flags
// (RULE12) literal repeat runs next op count plus one times, itself one cycle
// (RULE13) register repeat runs next op register value plus one times
// (RULE14) return with literal loads a 10-bit literal, three cycles or two
// (RULE15) multi-cycle ops stall following reads until results are written
package cis_pkg;
	localparam int unsigned DW       = 16;
	localparam int unsigned RAW      = 4;
	localparam int unsigned LIT5_W   = 5;
	localparam int unsigned LIT10_W  = 10;
	localparam int unsigned LIT14_W  = 14;
	localparam int unsigned FLAG_W   = 5;
	// flag vector positions
	localparam int unsigned FLG_C    = 0;
	localparam int unsigned FLG_DC   = 1;
	localparam int unsigned FLG_N    = 2;
	localparam int unsigned FLG_OV   = 3;
	localparam int unsigned FLG_Z    = 4;
	localparam logic [3:0]  DWREG    = 4'h0;
	localparam logic [15:0] SP_RST   = 16'h0800;
	localparam logic [15:0] SP_STEP  = 16'h0002;
	localparam logic [1:0]  RET_CYC  = 2'h3;
	localparam logic [1:0]  RET_FAST = 2'h2;
	localparam logic [13:0] REP_ZERO = 14'h0000;

	typedef enum logic [3:0] {
		CIS_OP_NONE,
		CIS_OP_MULTIPLY_SIGNED_SIGNED,
		CIS_OP_MULTIPLY_SIGNED_UNSIGNED,
		CIS_OP_MULTIPLY_UNSIGNED_SIGNED,
		CIS_OP_MULTIPLY_UNSIGNED_UNSIGNED,
		CIS_OP_MUL_SL,
		CIS_OP_MUL_UL,
		CIS_OP_NEG,
		CIS_OP_POP,
		CIS_OP_POP_D,
		CIS_OP_PUSH,
		CIS_OP_PUSH_D,
		CIS_OP_POWER_SAVE_ENTRY,
		CIS_OP_REP_LIT,
		CIS_OP_REP_REG,
		CIS_OP_RETURN_WITH_LITERAL
	} cis_op_e;
endpackage

//--- src/cis_mult.sv
/*
 * Registered 17x17 signed multiplier; each operand is sign or zero
 * extended by its select bit, so one array serves all four modes.
 * Assumes operands are stable in the issue cycle only.
 */
`timescale 1ns/100ps
module cis_mult (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic [cis_pkg::DW-1:0] a,
	input  wire logic [cis_pkg::DW-1:0] b,
	input  wire logic                 a_signed,
	input  wire logic                 b_signed,
	output logic [2*cis_pkg::DW-1:0]  product
);
	import cis_pkg::*;
	wire signed [DW:0]     a_ext = {a_signed & a[DW-1], a};
	wire signed [DW:0]     b_ext = {b_signed & b[DW-1], b};
	wire signed [2*DW+1:0] full  = (2*DW+2)'(a_ext) * (2*DW+2)'(b_ext);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			product <= '0;
		end else begin
			product <= full[2*DW-1:0];
		end
	end
endmodule

//--- src/cis_exec.sv
/*
 * Execution slice for multiplies, negate, push/pop, power save, repeat
 * and return with literal. Results go out as register, memory and
 * stack write strobes from one cycle after issue.
 * Assumes the decoder supplies operands read at issue, holds issue while
 * busy is high, and that the stack memory answers a read in the same
 * cycle through stack_rdata.
 */
`timescale 1ns/100ps
module cis_exec (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      issue,
	input  wire cis_pkg::cis_op_e          op,
	input  wire logic [cis_pkg::RAW-1:0]   dst,
	input  wire logic [cis_pkg::DW-1:0]    src_a,
	input  wire logic [cis_pkg::DW-1:0]    src_b,
	input  wire logic [cis_pkg::DW-1:0]    src_b_hi,
	input  wire logic [cis_pkg::LIT14_W-1:0] lit,
	input  wire logic                      neg_to_mem,
	input  wire logic                      fast_return,
	input  wire logic                      wdt_timeout,
	input  wire logic [cis_pkg::DW-1:0]    stack_rdata,
	output logic                           busy,
	output logic                           reg_we,
	output logic [cis_pkg::RAW-1:0]        reg_waddr,
	output logic [cis_pkg::DW-1:0]         reg_wdata,
	output logic                           mem_we,
	output logic [cis_pkg::DW-1:0]         mem_wdata,
	output logic                           stack_we,
	output logic                           stack_re,
	output logic [cis_pkg::DW-1:0]         stack_ptr,
	output logic [cis_pkg::DW-1:0]         stack_wdata,
	output logic                           flags_we,
	output logic [cis_pkg::FLAG_W-1:0]     flags,
	output logic                           sleep_mode,
	output logic                           idle_mode,
	output logic                           watchdog_timeout_flag,
	output logic                           sleep_flag,
	output logic                           ret_pulse,
	output logic [cis_pkg::LIT14_W-1:0]    repeat_left,
	output logic                           repeat_active
);
	import cis_pkg::*;

	typedef enum logic [1:0] {
		CIS_IDLE,
		CIS_MUL_WB,
		CIS_SECOND,
		CIS_RET
	} cis_state_e;

	cis_state_e       state;
	cis_op_e          op_q;
	logic [RAW-1:0]   dst_q;
	logic [DW-1:0]    hold_q;
	logic [1:0]       ret_cnt;
	logic [2*DW-1:0]  product;
	logic             hi_we;
	logic [RAW-1:0]   hi_addr;
	logic [DW-1:0]    hi_data;

	////////////////////////////////////////////////////////////////////////
	// decode of the issued operation
	// no take while the high product word still owns the register port
	wire take     = issue & (state == CIS_IDLE) & ~hi_we;
	wire is_mul   = (op >= CIS_OP_MULTIPLY_SIGNED_SIGNED) & (op <= CIS_OP_MUL_UL);
	wire lit_mul  = (op == CIS_OP_MUL_SL) | (op == CIS_OP_MUL_UL);
	wire a_sgn    = (op == CIS_OP_MULTIPLY_SIGNED_SIGNED) | (op == CIS_OP_MULTIPLY_SIGNED_UNSIGNED) |
	                (op == CIS_OP_MUL_SL); // see (RULE2)
	wire b_sgn    = (op == CIS_OP_MULTIPLY_SIGNED_SIGNED) | (op == CIS_OP_MULTIPLY_UNSIGNED_SIGNED); // see (RULE3)
	wire [DW-1:0] lit5_ext = {{(DW-LIT5_W){1'b0}}, lit[LIT5_W-1:0]};
	wire [DW-1:0] mul_b    = lit_mul ? lit5_ext : src_b; // see (RULE4) (RULE5)

	// negate: 0 - x, carry is set only when x is zero (no borrow)
	wire [DW-1:0] neg_res = ~src_a + 16'h0001; // see (RULE6)
	wire          neg_c   = (src_a == 16'h0000);
	wire          neg_dc  = (src_a[3:0] == 4'h0);
	wire          neg_ov  = (src_a == 16'h8000);
	wire [FLAG_W-1:0] neg_flags = {neg_res == 16'h0000, neg_ov,
	                               neg_res[DW-1], neg_dc, neg_c};

	wire [DW-1:0] sp_down  = stack_ptr - SP_STEP;
	wire [DW-1:0] sp_up    = stack_ptr + SP_STEP;
	wire [LIT14_W-1:0] rep_count = (op == CIS_OP_REP_LIT) ? lit :
	                               src_a[LIT14_W-1:0];
	wire [DW-1:0] lit10_ext = {{(DW-LIT10_W){1'b0}}, lit[LIT10_W-1:0]};
	wire [1:0]    ret_len   = fast_return ? RET_FAST : RET_CYC;
	wire          repeat_step = take & repeat_active & (op != CIS_OP_REP_LIT) &
	                            (op != CIS_OP_REP_REG);

	////////////////////////////////////////////////////////////////////////
	cis_mult u_mult (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.a        (src_a),
		.b        (mul_b),
		.a_signed (a_sgn),
		.b_signed (b_sgn),
		.product  (product)
	); // see (RULE1)

	////////////////////////////////////////////////////////////////////////
	// sequencing; busy stalls the decoder while a second write is pending
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state   <= CIS_IDLE;
			op_q    <= CIS_OP_NONE;
			dst_q   <= '0;
			hold_q  <= '0;
			ret_cnt <= '0;
			busy    <= 1'b0;
		end else begin
			unique case (state)
				CIS_IDLE: begin
					op_q   <= op;
					dst_q  <= dst;
					hold_q <= src_b_hi;
					busy   <= 1'b0;
					if (take & is_mul) begin
						state <= CIS_MUL_WB;
						busy  <= 1'b1; // see (RULE15)
					end else if (take & ((op == CIS_OP_POP_D) |
					                     (op == CIS_OP_PUSH_D))) begin
						state <= CIS_SECOND; // see (RULE8) (RULE10)
						busy  <= 1'b1;
					end else if (take & (op == CIS_OP_RETURN_WITH_LITERAL)) begin
						state   <= CIS_RET; // see (RULE14)
						ret_cnt <= ret_len - 2'h1;
						busy    <= 1'b1;
					end
				end
				// busy stays up one more cycle for the high word write
				CIS_MUL_WB: begin
					state <= CIS_IDLE;
				end
				CIS_SECOND: begin
					state <= CIS_IDLE;
					busy  <= 1'b0;
				end
				CIS_RET: begin
					ret_cnt <= ret_cnt - 2'h1;
					if (ret_cnt == 2'h1) begin
						state <= CIS_IDLE;
						busy  <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write ports; multiply low word is written at issue+2, high at issue+3
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_we      <= 1'b0;
			reg_waddr   <= '0;
			reg_wdata   <= '0;
			mem_we      <= 1'b0;
			mem_wdata   <= '0;
			stack_we    <= 1'b0;
			stack_re    <= 1'b0;
			stack_wdata <= '0;
			stack_ptr   <= SP_RST;
			flags_we    <= 1'b0;
			flags       <= '0;
			ret_pulse   <= 1'b0;
		end else begin
			reg_we    <= 1'b0;
			mem_we    <= 1'b0;
			stack_we  <= 1'b0;
			stack_re  <= 1'b0;
			flags_we  <= 1'b0;
			ret_pulse <= 1'b0;
			if (state == CIS_MUL_WB) begin
				reg_we    <= 1'b1;
				reg_waddr <= dst_q;
				reg_wdata <= product[DW-1:0];
			end else if (hi_we) begin
				reg_we    <= 1'b1; // see (RULE1)
				reg_waddr <= hi_addr;
				reg_wdata <= hi_data;
			end else if (state == CIS_SECOND && op_q == CIS_OP_POP_D) begin
				reg_we    <= 1'b1;
				reg_waddr <= dst_q; // see (RULE8)
				reg_wdata <= stack_rdata;
				stack_ptr <= sp_down;
				stack_re  <= 1'b1;
			end else if (state == CIS_SECOND) begin
				stack_we    <= 1'b1; // see (RULE10)
				stack_wdata <= hold_q;
				stack_ptr   <= sp_up;
			end else if (state == CIS_RET && ret_cnt == 2'h1) begin
				ret_pulse <= 1'b1;
			end else if (take) begin
				unique case (op)
					CIS_OP_NEG: begin
						reg_we    <= ~neg_to_mem;
						reg_waddr <= neg_to_mem ? dst : DWREG;
						reg_wdata <= neg_res;
						mem_we    <= neg_to_mem;
						mem_wdata <= neg_res;
						flags_we  <= 1'b1; // see (RULE6)
						flags     <= neg_flags;
					end
					CIS_OP_POP, CIS_OP_POP_D: begin
						reg_we    <= 1'b1; // see (RULE7)
						reg_waddr <= (op == CIS_OP_POP_D) ? dst + 4'h1 : dst;
						reg_wdata <= stack_rdata;
						stack_re  <= 1'b1;
						stack_ptr <= sp_down;
					end
					CIS_OP_PUSH, CIS_OP_PUSH_D: begin
						stack_we    <= 1'b1; // see (RULE9)
						stack_wdata <= src_b;
						stack_ptr   <= sp_up;
					end
					CIS_OP_RETURN_WITH_LITERAL: begin
						reg_we    <= 1'b1; // see (RULE14)
						reg_waddr <= dst;
						reg_wdata <= lit10_ext;
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power save and repeat
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sleep_mode            <= 1'b0;
			idle_mode             <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
			sleep_flag            <= 1'b0;
			repeat_left           <= REP_ZERO;
			repeat_active         <= 1'b0;
		end else begin
			// a timeout event wins over the clearing done by entry
			if (take & (op == CIS_OP_POWER_SAVE_ENTRY)) begin
				sleep_mode            <= ~lit[0]; // see (RULE11)
				idle_mode             <= lit[0];
				sleep_flag            <= ~lit[0];
				watchdog_timeout_flag <= wdt_timeout;
			end else if (wdt_timeout) begin
				watchdog_timeout_flag <= 1'b1;
				sleep_mode            <= 1'b0;
				idle_mode             <= 1'b0;
			end
			if (take & ((op == CIS_OP_REP_LIT) | (op == CIS_OP_REP_REG))) begin
				repeat_left   <= rep_count; // see (RULE12) (RULE13)
				repeat_active <= 1'b1;
			end else if (repeat_step) begin
				repeat_left   <= repeat_left - 14'h0001;
				repeat_active <= (repeat_left != REP_ZERO);
			end
		end
	end

	// high word held for the shared write port one cycle after the low word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hi_we   <= 1'b0;
			hi_addr <= '0;
			hi_data <= '0;
		end else begin
			hi_we   <= (state == CIS_MUL_WB); // see (RULE1)
			hi_addr <= dst_q + 4'h1;
			hi_data <= product[2*DW-1:DW];
		end
	end
endmodule

//--- dv/cis_exec_monitor.sv
/* checker for the execution slice: write timing and values at the ports.
   assumes a bind onto cis_exec, one clock and a synchronous reset. */
`timescale 1ns/100ps
module cis_exec_monitor
	import cis_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic             issue,
	input wire cis_pkg::cis_op_e op,
	input wire logic [3:0]       dst,
	input wire logic [15:0]      src_a,
	input wire logic [15:0]      src_b,
	input wire logic [15:0]      src_b_hi,
	input wire logic [13:0]      lit,
	input wire logic             neg_to_mem,
	input wire logic             fast_return,
	input wire logic             busy,
	input wire logic             reg_we,
	input wire logic [3:0]       reg_waddr,
	input wire logic [15:0]      reg_wdata,
	input wire logic [15:0]      mem_wdata,
	input wire logic             stack_we,
	input wire logic             stack_re,
	input wire logic [15:0]      stack_wdata,
	input wire logic             flags_we,
	input wire logic             sleep_mode,
	input wire logic             ret_pulse,
	input wire logic [13:0]      repeat_left
);
////////////////////////////////////////////////////////////////
	wire logic        take   = issue && !busy;
	wire logic        is_mul = op inside {CIS_OP_MULTIPLY_SIGNED_SIGNED, CIS_OP_MULTIPLY_SIGNED_UNSIGNED,
		CIS_OP_MULTIPLY_UNSIGNED_SIGNED, CIS_OP_MULTIPLY_UNSIGNED_UNSIGNED, CIS_OP_MUL_SL, CIS_OP_MUL_UL};
	wire logic        is_lm  = op inside {CIS_OP_MUL_SL, CIS_OP_MUL_UL};
	// only the low five literal bits may reach the multiplier
	wire logic [15:0] lit5   = {11'h000, lit[4:0]};
	wire logic        lsel   = lit[0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
////////////////////////////////////////////////////////////////
	property p_mul_busy; take && is_mul |=> busy ##1 busy; endproperty
	a_mul_busy: assert property (p_mul_busy) else $error("no busy");
	property p_mul_low;
		take && is_mul |-> ##2 reg_we && reg_waddr == $past(dst, 2);
	endproperty
	a_mul_low: assert property (p_mul_low) else $error("mul write");
	property p_mul_high; take && is_mul |-> ##3 reg_we &&
		reg_waddr == 4'($past(dst, 3) + 4'h1);
	endproperty
	a_mul_high: assert property (p_mul_high) else $error("mul high");
	property p_pop; take && op == CIS_OP_POP |=> reg_we && stack_re &&
		!flags_we && reg_waddr == $past(dst);
	endproperty
	a_pop: assert property (p_pop) else $error("pop write");
	property p_mul_flag; take && is_mul |=> !flags_we [*2]; endproperty
	a_mul_flag: assert property (p_mul_flag) else $error("mul flags");
	property p_mul_lit;
		take && is_lm |-> ##2 reg_wdata == 16'($past(src_a, 2) * $past(lit5, 2));
	endproperty
	a_mul_lit: assert property (p_mul_lit) else $error("lit product");
	property p_neg; take && op == CIS_OP_NEG |=> flags_we &&
		($past(neg_to_mem) ? mem_wdata : reg_wdata) == 16'(~$past(src_a) + 16'h1);
	endproperty
	a_neg: assert property (p_neg) else $error("negate result");
	property p_pop_d; take && op == CIS_OP_POP_D |=> reg_we && stack_re &&
		reg_waddr == 4'($past(dst) + 4'h1) ##1 reg_we && reg_waddr == $past(dst, 2);
	endproperty
	a_pop_d: assert property (p_pop_d) else $error("pair pop order");
	property p_push; take && op == CIS_OP_PUSH |=> stack_we && !flags_we &&
		stack_wdata == $past(src_b);
	endproperty
	a_push: assert property (p_push) else $error("push write");
	property p_push_d; take && op == CIS_OP_PUSH_D |=> stack_we ##1
		stack_we && stack_wdata == $past(src_b_hi, 2);
	endproperty
	a_push_d: assert property (p_push_d) else $error("pair push");
	property p_ret; take && op == CIS_OP_RETURN_WITH_LITERAL |->
		if (fast_return) ##2 ret_pulse else ##3 ret_pulse;
	endproperty
	a_ret: assert property (p_ret) else $error("return timing");
	property p_pwr; take && op == CIS_OP_POWER_SAVE_ENTRY |=> sleep_mode == !$past(lsel);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power mode");
	property p_rep; take && op == CIS_OP_REP_LIT |=> repeat_left == $past(lit);
	endproperty
	a_rep: assert property (p_rep) else $error("repeat count");
	cover property (take && op == CIS_OP_POP_D);
	cover property (take && op == CIS_OP_RETURN_WITH_LITERAL && fast_return);
	cover property (take && op == CIS_OP_NEG && neg_to_mem);
endmodule

bind cis_exec cis_exec_monitor i_cis_exec_monitor (.ref_clk, .rst, .issue,
	.op, .dst, .src_a, .src_b, .src_b_hi, .lit, .neg_to_mem, .fast_return,
	.busy, .reg_we, .reg_waddr, .reg_wdata, .mem_wdata, .stack_we, .stack_re,
	.stack_wdata, .flags_we, .sleep_mode, .ret_pulse, .repeat_left);

//--- dv/cis_stack_model.sv
/* stack memory and register file standing beside the execution slice.
   assumes stack_ptr addresses the word read or written this cycle. */
`timescale 1ns/100ps
module cis_stack_model (
	input  wire logic        ref_clk,
	input  wire logic        stack_we,
	input  wire logic [15:0] stack_ptr,
	input  wire logic [15:0] stack_wdata,
	input  wire logic        reg_we,
	input  wire logic [3:0]  reg_waddr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] stack_rdata
);
	logic [15:0] mem [256];
	logic [15:0] rf [16];
	logic [15:0] mem_last = 16'h0000;
	// unwritten words read as the inverted index, never a quiet zero
	initial for (int i = 0; i < 256; i++) mem[i] = 16'(~i);
	initial for (int i = 0; i < 16; i++) rf[i] = 16'h0000;
	always_comb stack_rdata = mem[stack_ptr[8:1]];
	always @(posedge ref_clk) begin
		if (stack_we) mem[stack_ptr[8:1]] <= stack_wdata;
		if (reg_we) rf[reg_waddr] <= reg_wdata;
		if (mem_we) mem_last <= mem_wdata;
	end
endmodule

//--- dv/tb.sv
/* self-checking bench for cis_exec, one task per scenario.
   assumes the stack model answers reads and records every write. */
`timescale 1ns/100ps
module tb;
	import cis_pkg::*;
	logic        ref_clk = 1'b0, rst = 1'b1, issue = 1'b0, wdt_timeout = 1'b0;
	logic        neg_to_mem = 1'b0, fast_return = 1'b0;
	cis_op_e     op = CIS_OP_NONE;
	logic [3:0]  dst = 4'h0, reg_waddr;
	logic [15:0] src_a = 16'h0, src_b = 16'h0, src_b_hi = 16'h0;
	logic [13:0] lit = 14'h0, repeat_left;
	logic [15:0] stack_rdata, reg_wdata, mem_wdata, stack_ptr, stack_wdata;
	logic [4:0]  flags;
	logic        busy, reg_we, mem_we, stack_we, stack_re, flags_we, ret_pulse;
	logic        sleep_mode, idle_mode, watchdog_timeout_flag, sleep_flag;
	logic        repeat_active;
	int          fails = 0, tests_run = 0;
	always #2.5 ref_clk = ~ref_clk;
	cis_exec i_cis_exec (.ref_clk, .rst, .issue, .op, .dst, .src_a, .src_b,
		.src_b_hi, .lit, .neg_to_mem, .fast_return, .wdt_timeout, .stack_rdata,
		.busy, .reg_we, .reg_waddr, .reg_wdata, .mem_we, .mem_wdata, .stack_we,
		.stack_re, .stack_ptr, .stack_wdata, .flags_we, .flags, .sleep_mode,
		.idle_mode, .watchdog_timeout_flag, .sleep_flag, .ret_pulse,
		.repeat_left, .repeat_active);
	cis_stack_model i_cis_stack_model (.ref_clk, .stack_we, .stack_ptr,
		.stack_wdata, .reg_we, .reg_waddr, .reg_wdata, .mem_we, .mem_wdata,
		.stack_rdata);
////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic do_reset;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
	endtask
	// issue only when idle: a request under busy would be dropped silently
	task automatic go(input cis_op_e o, input logic [3:0] d,
		input logic [15:0] a, b, bh, input logic [13:0] l);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 50) begin
			fails++;
			conclude();
		end
		op       = o;
		dst      = d;
		src_a    = a;
		src_b    = b;
		src_b_hi = bh;
		lit      = l;
		issue    = 1'b1;
		@(posedge ref_clk);
		#1 issue = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
////////////////////////////////////////////////////////////////
	task automatic t_mul;
		cis_op_e o [6] = '{CIS_OP_MULTIPLY_SIGNED_SIGNED, CIS_OP_MULTIPLY_SIGNED_UNSIGNED, CIS_OP_MULTIPLY_UNSIGNED_SIGNED,
			CIS_OP_MULTIPLY_UNSIGNED_UNSIGNED, CIS_OP_MUL_SL, CIS_OP_MUL_UL};
		// b has its top bit set so operand signedness shows in the high word
		logic [31:0] e [6] = '{32'h0000fffa, 32'hfffe7ff7, 32'h8004fff4,
			32'h80007ff1, 32'hffffff46, 32'h0002ffeb};
		logic [15:0] a;
		logic [13:0] l;
		for (int i = 0; i < 6; i++) begin
			a = 16'hfffe - 16'(i);
			l = i[0] ? 14'h3fe3 : 14'h3fff;
			go(o[i], 4'h4, a, 16'h8003, 16'h0, l);
			chk("mul low", i_cis_stack_model.rf[4], e[i][15:0]);
			chk("mul high", i_cis_stack_model.rf[5], e[i][31:16]);
		end
		$display("done multiply");
	endtask
	task automatic t_neg;
		logic [15:0] a [3] = '{16'h0001, 16'h0000, 16'h8000};
		logic [4:0]  f [3] = '{5'h04, 5'h13, 5'h0e};
		for (int i = 0; i < 3; i++) begin
			neg_to_mem = (i > 0);
			go(CIS_OP_NEG, 4'h0, a[i], 16'h0, 16'h0, 14'h0);
			chk("neg flags", flags, f[i]);
			chk("neg value", i ? i_cis_stack_model.mem_last :
				i_cis_stack_model.rf[DWREG], 16'(~a[i] + 16'h1));
		end
		chk("neg reg kept", i_cis_stack_model.rf[DWREG], 16'hffff);
		neg_to_mem = 1'b0;
		$display("done negate");
	endtask
	task automatic t_stack;
		go(CIS_OP_PUSH, 4'h0, 16'h0, 16'h1357, 16'h0, 14'h0);
		chk("ptr push", stack_ptr, SP_RST + SP_STEP);
		go(CIS_OP_PUSH_D, 4'h0, 16'h0, 16'h2468, 16'h9abc, 14'h0);
		go(CIS_OP_POP_D, 4'h6, 16'h0, 16'h0, 16'h0, 14'h0);
		chk("pop hi", i_cis_stack_model.rf[7], 16'h9abc);
		chk("pop lo", i_cis_stack_model.rf[6], 16'h2468);
		go(CIS_OP_POP, 4'h9, 16'h0, 16'h0, 16'h0, 14'h0);
		chk("pop one", i_cis_stack_model.rf[9], 16'h1357);
		chk("ptr back", stack_ptr, SP_RST);
		$display("done stack");
	endtask
	task automatic t_ret;
		go(CIS_OP_RETURN_WITH_LITERAL, 4'h3, 16'h0, 16'h0, 16'h0, 14'h3abc);
		chk("ret lit", i_cis_stack_model.rf[3], 16'h02bc);
		fast_return = 1'b1;
		go(CIS_OP_RETURN_WITH_LITERAL, 4'h5, 16'h0, 16'h0, 16'h0, 14'h0155);
		chk("fast ret lit", i_cis_stack_model.rf[5], 16'h0155);
		fast_return = 1'b0;
		$display("done return");
	endtask
	task automatic t_rep;
		go(CIS_OP_REP_LIT, 4'h0, 16'h0, 16'h0, 16'h0, 14'h3fff);
		chk("rep lit", {repeat_active, repeat_left}, 15'h7fff);
		go(CIS_OP_REP_LIT, 4'h0, 16'h0, 16'h0, 16'h0, 14'h0001);
		go(CIS_OP_NONE, 4'h0, 16'h0, 16'h0, 16'h0, 14'h0);
		chk("rep step", {repeat_active, repeat_left}, 15'h4000);
		go(CIS_OP_NONE, 4'h0, 16'h0, 16'h0, 16'h0, 14'h0);
		chk("rep done", repeat_active, 1'b0);
		do_reset();
		go(CIS_OP_REP_REG, 4'h0, 16'hc005, 16'h0, 16'h0, 14'h0);
		chk("rep reg", {repeat_active, repeat_left}, 15'h4005);
		do_reset();
		$display("done repeat");
	endtask
	task automatic t_pwr;
		go(CIS_OP_POWER_SAVE_ENTRY, 4'h0, 16'h0, 16'h0, 16'h0, 14'h0000);
		chk("sleep", {sleep_mode, idle_mode, sleep_flag,
			watchdog_timeout_flag}, 4'b1010);
		do_reset();
		go(CIS_OP_POWER_SAVE_ENTRY, 4'h0, 16'h0, 16'h0, 16'h0, 14'h0001);
		chk("idle", {sleep_mode, idle_mode}, 2'b01);
		wdt_timeout = 1'b1;
		@(posedge ref_clk);
		#1 wdt_timeout = 1'b0;
		@(posedge ref_clk);
		#1 chk("timeout", watchdog_timeout_flag, 1'b1);
		chk("wake", {sleep_mode, idle_mode}, 2'b00);
		$display("done power save");
	endtask
	initial begin
		do_reset();
		t_mul();
		t_neg();
		t_stack();
		t_ret();
		t_rep();
		t_pwr();
		conclude();
	end
endmodule
